//--- tfr_pkg.sv
// package: register map, field layout and error codes for the translation fault recorder
`default_nettype none
package tfr_pkg;
  // ==========================================================
  // register byte addresses
  localparam logic [15:0] ADDR_RENDER_FAULT = 16'h4094;
  localparam logic [15:0] ADDR_MEDIA_FAULT = 16'h4194;
  localparam logic [15:0] ADDR_COPY_FAULT = 16'h4294;
  localparam logic [15:0] ADDR_ERR_STATUS = 16'h40b0;
  localparam logic [15:0] ADDR_ERR_MASK = 16'h40b4;
  localparam logic [15:0] ADDR_ERR_IDENT = 16'h40b8;
  localparam logic [15:0] ADDR_INT_IDENT = 16'h40a4;
  localparam logic [15:0] ADDR_SRC_ERR = 16'h40bc;
  // ==========================================================
  // fault record fields
  localparam int FR_VPAGE_HI = 31;
  localparam int FR_VPAGE_LO = 12;
  localparam int FR_TSEL = 11;
  localparam int FR_SRC_HI = 10;
  localparam int FR_SRC_LO = 3;
  localparam int FR_VALID = 0;
  localparam int NUM_ENG = 3;
  // ==========================================================
  // error status bits, common to status, mask and identity
  localparam int ERR_W = 4;
  localparam int ERR_INV_ENTRY = 0;
  localparam int ERR_UNEXP_MISS = 1;
  localparam int ERR_INV_DATA = 2;
  localparam int ERR_INV_TILING = 3;
  localparam logic [ERR_W-1:0] ERR_PT_MASK = 4'hf;
  localparam logic [ERR_W-1:0] MASK_RESET = 4'hf;
  // master error bit of interrupt identity
  localparam int INT_MASTER_ERR = 15;
  // ==========================================================
  // stream kinds and tiling modes
  localparam logic [2:0] STR_RENDER = 3'h0;
  localparam logic [2:0] STR_MEDIA = 3'h1;
  localparam logic [2:0] STR_BLIT = 3'h2;
  localparam logic [2:0] STR_DISPLAY = 3'h3;
  localparam logic [2:0] STR_OVERLAY = 3'h4;
  localparam logic [2:0] STR_HOST = 3'h5;
  localparam logic [1:0] TILE_Y = 2'h2;
  localparam logic [1:0] TILE_BAD = 2'h3;
  localparam int ENTRY_VALID = 0;
  typedef enum logic [1:0] {
    APB_IDLE = 2'b00,
    APB_ACCESS = 2'b01
  } tfr_apb_t;
endpackage
`default_nettype wire

//--- tfr_fault_slot.sv
// one engine's first-fault record register
`default_nettype none
module tfr_fault_slot (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic fault,
  input wire logic [19:0] fault_vpage,
  input wire logic fault_tsel,
  input wire logic [7:0] fault_src,
  input wire logic sw_wr,
  input wire logic [31:0] sw_wdata,
  output logic [31:0] rec
);
  logic valid_r;
  logic [19:0] vpage_r;
  logic tsel_r;
  logic [7:0] src_r;
  // ==========================================================
  // capture the first fault; software writing zero to valid re-arms and wipes fields
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      valid_r <= 1'b0;
      vpage_r <= 20'h0;
      tsel_r <= 1'b0;
      src_r <= 8'h0;
    end else if (fault && (!valid_r || (sw_wr && !sw_wdata[tfr_pkg::FR_VALID]))) begin
      // a fault in the clear cycle is caught, not lost
      valid_r <= 1'b1;
      vpage_r <= fault_vpage;
      tsel_r <= fault_tsel;
      src_r <= fault_src;
    end else if (sw_wr && !sw_wdata[tfr_pkg::FR_VALID]) begin
      valid_r <= 1'b0;
      vpage_r <= 20'h0;
      tsel_r <= 1'b0;
      src_r <= 8'h0;
    end
  end
  // reserved bits 2:1 read zero
  assign rec = {vpage_r, tsel_r, src_r, 2'b00, valid_r};
endmodule // tfr_fault_slot
`default_nettype wire

//--- tfr_recorder.sv
// translation fault recorder: error classification, cycle invalidation, fault records, apb regs
// Notes on behaviour
// - invalid table entry raises page table error
// - display/overlay lookaside miss raises unexpected-miss error
// - host entry to forbidden page raises error
// - bad tiling on blit/display/overlay raises error
// - page table errors clear only on reset
// - fault captures address, marks cycles invalid
// - invalid write dropped, invalid read returns zero
// - cached invalid entry keeps producing invalid cycles
// - each engine records only first fault
// - bits 31:12 hold frozen virtual page
// - bit 11 holds frozen table select
// - bits 10:3 hold frozen source id
// - valid resets zero, clearing wipes fields
// - identity write-one clears matching status bit
// - write-one clears master error bit
// - any identity bit raises master error
// - mask selects latched identity bits, persistent
//
// Decided for this implementation: the APB slave port.
`default_nettype none
module tfr_recorder (
  input wire logic clk_sys,
  input wire logic srst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // client request, one cycle per pulse
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [31:0] req_vaddr,
  input wire logic [31:0] req_wdata,
  input wire logic [2:0] req_stream,
  input wire logic [7:0] req_source_id,
  input wire logic req_table_select,
  input wire logic [1:0] req_tiling,
  input wire logic req_tlb_hit,
  input wire logic [31:0] req_entry,
  input wire logic req_page_forbidden,
  // client response
  output logic rsp_valid,
  output logic rsp_invalid,
  output logic [31:0] rsp_rdata,
  // downstream memory queue
  output logic mq_valid,
  output logic mq_write,
  output logic [31:0] mq_addr,
  output logic [31:0] mq_wdata,
  input wire logic [31:0] mq_rdata,
  // master error level toward interrupt logic
  output logic master_error
);
  localparam int ERR_W_L = tfr_pkg::ERR_W;
  // error status, mask, identity and sticky source bits, one per error kind
  logic [ERR_W_L-1:0] err_status_r;
  logic [ERR_W_L-1:0] err_mask_r;
  logic [ERR_W_L-1:0] err_ident_r;
  logic [ERR_W_L-1:0] src_err_r;
  logic master_r;
  // per-request decode and register bus strobes
  logic [ERR_W_L-1:0] err_event;
  logic fault_now;
  logic [2:0] fault_hit;
  logic [2:0] slot_wr;
  logic [31:0] rec [3];
  logic apb_wr;
  logic apb_rd;
  logic ident_wr;
  logic int_wr;
  logic src_wr;
  logic [31:0] rd_nxt;
  logic hit_map;
  tfr_pkg::tfr_apb_t apb_r;
  // stream classes for the request-time checks
  logic strm_disp_ovl;
  logic strm_tiling_chk;
  logic strm_y_bad;

  // ==========================================================
  // stream classes: display and overlay expect lookaside hits; y-major is illegal on render, display and overlay
  assign strm_disp_ovl = req_stream == tfr_pkg::STR_DISPLAY ||
    req_stream == tfr_pkg::STR_OVERLAY;
  assign strm_y_bad = req_stream == tfr_pkg::STR_RENDER || strm_disp_ovl;
  assign strm_tiling_chk = req_stream == tfr_pkg::STR_BLIT || strm_y_bad;

  // error classification; every check is made at request time
  always_comb begin
    err_event = '0;
    if (req_valid) begin
      err_event[tfr_pkg::ERR_INV_ENTRY] = !req_entry[tfr_pkg::ENTRY_VALID];
      err_event[tfr_pkg::ERR_UNEXP_MISS] = !req_tlb_hit && strm_disp_ovl;
      err_event[tfr_pkg::ERR_INV_DATA] = req_page_forbidden &&
        (req_stream == tfr_pkg::STR_HOST);
      err_event[tfr_pkg::ERR_INV_TILING] = strm_tiling_chk &&
        (req_tiling == tfr_pkg::TILE_BAD || (req_tiling == tfr_pkg::TILE_Y && strm_y_bad));
    end
  end

  // the entry, whether freshly fetched or a cached lookaside hit, decides validity alike
  // an invalid entry cached in the lookaside buffer therefore faults on every hit
  assign fault_now = req_valid && !req_entry[tfr_pkg::ENTRY_VALID];

  // route fault to engine slot by stream
  // stream codes beyond host also land on the render record
  always_comb begin
    fault_hit = 3'b000;
    case (req_stream)
      tfr_pkg::STR_MEDIA: fault_hit[1] = fault_now;
      tfr_pkg::STR_BLIT: fault_hit[2] = fault_now;
      default: fault_hit[0] = fault_now; // render owns display, overlay, host streams
    endcase
  end

  // ==========================================================
  // downstream queue: invalid writes never leave, reads of invalid cycles come back zero
  // write data still moves on a dropped write; mq_valid low is what keeps it out
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mq_valid <= 1'b0;
      mq_write <= 1'b0;
      mq_addr <= 32'h0;
      mq_wdata <= 32'h0;
    end else begin
      mq_valid <= req_valid && !(fault_now && req_write);
      mq_write <= req_write;
      mq_addr <= {req_entry[tfr_pkg::FR_VPAGE_HI:tfr_pkg::FR_VPAGE_LO], req_vaddr[11:0]};
      mq_wdata <= req_wdata;
    end
  end

  // client answer; read data assumed returned by queue in the same cycle as the request
  // limitation: no tag pairs late queue data with its request, so the queue must not lag
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rsp_valid <= 1'b0;
      rsp_invalid <= 1'b0;
      rsp_rdata <= 32'h0;
    end else begin
      rsp_valid <= req_valid;
      rsp_invalid <= fault_now;
      rsp_rdata <= (fault_now || req_write) ? 32'h0 : mq_rdata;
    end
  end

  // ==========================================================
  // fault records, one per engine; the address is latched on fault
  // display, overlay and host traffic is charged to the render engine record
  genvar g;
  generate
    for (g = 0; g < tfr_pkg::NUM_ENG; g++) begin : g_slot
      tfr_fault_slot u_slot (
        .clk_sys(clk_sys),
        .srst(srst),
        .fault(fault_hit[g]),
        .fault_vpage(req_vaddr[tfr_pkg::FR_VPAGE_HI:tfr_pkg::FR_VPAGE_LO]),
        .fault_tsel(req_table_select),
        .fault_src(req_source_id),
        .sw_wr(slot_wr[g]),
        .sw_wdata(pwdata),
        .rec(rec[g])
      );
    end
  endgenerate

  // ==========================================================
  // apb decode: setup then one-cycle access, no wait states
  // a write lands only at the edge where the access phase meets pready
  assign apb_wr = psel && penable && pwrite && pready;
  assign apb_rd = psel && !penable && !pwrite;
  assign slot_wr[0] = apb_wr && paddr == tfr_pkg::ADDR_RENDER_FAULT;
  assign slot_wr[1] = apb_wr && paddr == tfr_pkg::ADDR_MEDIA_FAULT;
  assign slot_wr[2] = apb_wr && paddr == tfr_pkg::ADDR_COPY_FAULT;
  assign ident_wr = apb_wr && paddr == tfr_pkg::ADDR_ERR_IDENT;
  assign int_wr = apb_wr && paddr == tfr_pkg::ADDR_INT_IDENT;
  assign src_wr = apb_wr && paddr == tfr_pkg::ADDR_SRC_ERR;

  always_comb begin
    rd_nxt = 32'h0;
    hit_map = 1'b1;
    case (paddr)
      tfr_pkg::ADDR_RENDER_FAULT: rd_nxt = rec[0];
      tfr_pkg::ADDR_MEDIA_FAULT: rd_nxt = rec[1];
      tfr_pkg::ADDR_COPY_FAULT: rd_nxt = rec[2];
      tfr_pkg::ADDR_ERR_STATUS: rd_nxt = {28'h0, err_status_r};
      tfr_pkg::ADDR_ERR_MASK: rd_nxt = {28'h0, err_mask_r};
      tfr_pkg::ADDR_ERR_IDENT: rd_nxt = {28'h0, err_ident_r};
      tfr_pkg::ADDR_INT_IDENT: rd_nxt = {16'h0, master_r, 15'h0};
      tfr_pkg::ADDR_SRC_ERR: rd_nxt = {28'h0, src_err_r};
      default: hit_map = 1'b0;
    endcase
  end

  // handshake: pready rises in the access phase
  // read data is taken at the setup edge, so prdata stands through the access cycle
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      apb_r <= tfr_pkg::APB_IDLE;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      case (apb_r)
        tfr_pkg::APB_IDLE: begin
          pready <= 1'b0;
          if (psel && !penable) begin
            apb_r <= tfr_pkg::APB_ACCESS;
            pready <= 1'b1;
            pslverr <= !hit_map;
            if (apb_rd) begin
              prdata <= rd_nxt;
            end
          end
        end
        tfr_pkg::APB_ACCESS: begin
          // drop back so a stale word never reads as fresh
          apb_r <= tfr_pkg::APB_IDLE;
          pready <= 1'b0;
          pslverr <= 1'b0;
          prdata <= 32'h0;
        end
        default: apb_r <= tfr_pkg::APB_IDLE;
      endcase
    end
  end

  // ==========================================================
  // mask register; reset masks all errors
  // masking hides identity bits only; status keeps recording underneath
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      err_mask_r <= tfr_pkg::MASK_RESET;
    end else if (apb_wr && paddr == tfr_pkg::ADDR_ERR_MASK) begin
      err_mask_r <= pwdata[ERR_W_L-1:0];
    end
  end

  // functional source register: page table bits are sticky and ignore software
  // trade-off: these sources never clear, so status re-sets after a write-one
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      src_err_r <= '0;
    end else begin
      src_err_r <= src_err_r | (err_event & tfr_pkg::ERR_PT_MASK);
    end
  end

  // status follows sources; identity write-one clears a status bit, set wins
  // a new event in the clear cycle is kept rather than lost
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      err_status_r <= '0;
    end else begin
      err_status_r <= err_event | src_err_r |
        (err_status_r & ~(ident_wr ? pwdata[ERR_W_L-1:0] : '0));
    end
  end

  // identity latches unmasked status and persists until written one
  // one write may clear several bits, which is how software should do it
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      err_ident_r <= '0;
    end else begin
      err_ident_r <= (err_status_r & ~err_mask_r) |
        (err_ident_r & ~(ident_wr ? pwdata[ERR_W_L-1:0] : '0));
    end
  end

  // master error: set by any identity bit, write-one clear, set wins
  // a write-one has no effect while any identity bit is still set
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      master_r <= 1'b0;
    end else begin
      master_r <= (|err_ident_r) ||
        (master_r && !(int_wr && pwdata[tfr_pkg::INT_MASTER_ERR]));
    end
  end

  // output straight from flop
  // one extra flop costs a cycle but keeps the decode off the pin
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      master_error <= 1'b0;
    end else begin
      master_error <= master_r;
    end
  end

  // writes to the source register are accepted but have no effect on page table errors
  // the decode is kept so a later non page table source can hook in
  logic unused_src_wr;
  assign unused_src_wr = src_wr;
endmodule // tfr_recorder
`default_nettype wire

//--- tfr_recorder_chk.sv
// checker: port-level properties of the translation fault recorder
`default_nettype none
module tfr_recorder_chk (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [31:0] req_vaddr,
  input wire logic [31:0] req_entry,
  input wire logic rsp_valid,
  input wire logic rsp_invalid,
  input wire logic [31:0] rsp_rdata,
  input wire logic mq_valid,
  input wire logic [31:0] mq_addr,
  input wire logic [31:0] mq_rdata,
  input wire logic master_error
);
  // ====
  // one clock domain, so one default clock and reset
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  logic clr_m;
  // write-one to the master bit is the only way to drop it
  assign clr_m = psel && penable && pwrite && paddr == tfr_pkg::ADDR_INT_IDENT
    && pwdata[tfr_pkg::INT_MASTER_ERR];
  // ====
  // client side
  a_rsp_next: assert property (req_valid |=> rsp_valid)
    else $error("no response one cycle after request");
  a_no_spurious: assert property (!req_valid |=> !rsp_valid && !mq_valid)
    else $error("response without request");
  a_fault_invalid: assert property (req_valid && !req_entry[0] |=> rsp_invalid)
    else $error("invalid entry not flagged");
  a_drop_write: assert property (req_valid && req_write && !req_entry[0] |=> !mq_valid)
    else $error("invalid write reached the queue");
  a_zero_read: assert property (rsp_valid && rsp_invalid |-> rsp_rdata == 32'h0)
    else $error("invalid cycle returned data");
  a_read_data: assert property (req_valid && !req_write |=>
    rsp_invalid || rsp_rdata == $past(mq_rdata))
    else $error("read data differs from queue data");
  a_mq_addr: assert property (req_valid && req_entry[0] |=>
    mq_addr == {$past(req_entry[31:12]), $past(req_vaddr[11:0])})
    else $error("translated address wrong");
  // ====
  // register bus and master error
  a_apb_answer: assert property (psel && !penable |=> pready)
    else $error("no ready in access cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_master_hold: assert property (master_error && !clr_m && !$past(clr_m)
    && !$past(clr_m, 2) |=> master_error)
    else $error("master error dropped without clear");
  c_fault: cover property (req_valid && !req_entry[0]);
  c_write: cover property (req_valid && req_write && req_entry[0]);
  c_master: cover property ($fell(master_error));
endmodule // tfr_recorder_chk
bind tfr_recorder tfr_recorder_chk i_tfr_recorder_chk (.*);
`default_nettype wire

//--- tfr_mem_queue.sv
// partner: downstream memory queue answering reads with a moving pattern
`default_nettype none
module tfr_mem_queue (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic mq_valid,
  input wire logic [31:0] mq_addr,
  output logic [31:0] mq_rdata
);
  // ====
  // read data changes every cycle so a stale value never matches by luck
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mq_rdata <= 32'h13579bdf;
    end else begin
      mq_rdata <= mq_rdata + 32'h9e3779b9 + (mq_valid ? mq_addr : 32'h0);
    end
  end
endmodule // tfr_mem_queue
`default_nettype wire

//--- tfr_recorder_test.sv
// testbench: random traffic, engine fault records and error clearing
`default_nettype none
module tfr_recorder_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [15:0] paddr = 16'h0;
  logic [31:0] pwdata = 32'h0, prdata, rdv, mq_rdata, mq_addr, mq_wdata, rsp_rdata;
  logic pready, pslverr, rsp_valid, rsp_invalid, mq_valid, mq_write, master_error, err;
  logic req_valid = 1'b0, req_write = 1'b0, req_table_select = 1'b0;
  logic req_tlb_hit = 1'b1, req_page_forbidden = 1'b0, clean = 1'b1;
  logic [31:0] req_vaddr = 32'h0, req_wdata = 32'h0, req_entry = 32'h1, v;
  logic [2:0] req_stream = 3'h0;
  logic [7:0] req_source_id = 8'h0;
  logic [1:0] req_tiling = 2'h0;
  logic [15:0] rec_a [3] = '{tfr_pkg::ADDR_RENDER_FAULT, tfr_pkg::ADDR_MEDIA_FAULT,
    tfr_pkg::ADDR_COPY_FAULT};
  logic [2:0] est [5] = '{tfr_pkg::STR_RENDER, tfr_pkg::STR_DISPLAY, tfr_pkg::STR_HOST,
    tfr_pkg::STR_BLIT, tfr_pkg::STR_RENDER};
  int seed = 23335, num_errors = 0, n_checks = 0, cyc = 0;
  tfr_recorder i_tfr_recorder (.*);
  tfr_mem_queue i_tfr_mem_queue (.*);
  always #5 clk_sys = ~clk_sys;
  // ====
  // helpers
  task automatic summarize();
    if (num_errors == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // a hang ends the run through the same report
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      summarize();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer; request held until pready is seen
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [15:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdv, exp);
  endtask
  // record image expected from the request last sent
  function automatic logic [31:0] rexp();
    return {req_vaddr[31:12], req_table_select, req_source_id, 3'b001};
  endfunction
  task automatic reset_dut();
    @(posedge clk_sys);
    srst <= 1'b1;
    req_tlb_hit <= 1'b1;
    req_tiling <= 2'h0;
    req_page_forbidden <= 1'b0;
    clean = 1'b1;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
  endtask
  // one client request with random address, data and source
  task automatic send(input logic w, input logic [2:0] s, input logic [31:0] e);
    logic [31:0] d;
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req_write <= w;
    req_stream <= s;
    req_entry <= e;
    {req_vaddr, req_wdata} <= {$random(seed), $random(seed)};
    {req_source_id, req_table_select} <= 9'($random(seed));
    @(posedge clk_sys);
    req_valid <= 1'b0;
    d = mq_rdata;
    #1;
    chk(rsp_valid, 32'h1);
    if (clean) begin
      chk(rsp_invalid, {31'h0, !e[0]});
      chk(rsp_rdata, (w || !e[0]) ? 32'h0 : d);
      chk(mq_valid, {31'h0, !(w && !e[0])});
      chk(mq_write, {31'h0, w});
      chk(mq_wdata, req_wdata);
      if (e[0]) chk(mq_addr, {e[31:12], req_vaddr[11:0]});
    end
  endtask
  // ====
  // main sequence
  initial begin
    repeat (6) @(posedge clk_sys);
    srst <= 1'b0;
    for (int e = 0; e < 3; e++) rchk(rec_a[e], 32'h0);
    rchk(tfr_pkg::ADDR_ERR_MASK, 32'hf);
    rchk(16'h4000, 32'h0);
    chk(err, 32'h1);
    repeat (40) send(1'($random(seed)), 3'({$random(seed)} % 6), $random(seed));
    // first fault kept, later ones ignored until the valid bit is cleared
    for (int e = 0; e < 3; e++) begin
      reset_dut();
      send(1'b0, e[2:0], 32'h0);
      v = rexp();
      send(1'b1, e[2:0], 32'habcd0000);
      rchk(rec_a[e], v);
      apb(1'b1, rec_a[e], 32'h0);
      rchk(rec_a[e], 32'h0);
      send(1'b0, e[2:0], 32'h12345000);
      rchk(rec_a[e], rexp());
    end
    // each page table error kind, then the clearing sequence
    for (int k = 0; k < 5; k++) begin
      reset_dut();
      clean = 1'b0;
      req_tlb_hit <= (k != 1);
      req_page_forbidden <= (k == 2);
      req_tiling <= (k == 3) ? tfr_pkg::TILE_BAD : (k == 4) ? tfr_pkg::TILE_Y : 2'h0;
      send(1'b0, est[k], (k == 0) ? 32'h0 : 32'h1);
      v = 32'h1 << ((k < 3) ? k : 3);
      repeat (6) @(posedge clk_sys);
      rchk(tfr_pkg::ADDR_ERR_STATUS, v);
      rchk(tfr_pkg::ADDR_ERR_IDENT, 32'h0);
      chk(master_error, 32'h0);
      apb(1'b1, tfr_pkg::ADDR_ERR_MASK, 32'h0);
      repeat (6) @(posedge clk_sys);
      rchk(tfr_pkg::ADDR_ERR_IDENT, v);
      chk(master_error, 32'h1);
      apb(1'b1, tfr_pkg::ADDR_ERR_MASK, 32'hf);
      apb(1'b1, tfr_pkg::ADDR_ERR_IDENT, 32'hf);
      rchk(tfr_pkg::ADDR_ERR_IDENT, 32'h0);
      rchk(tfr_pkg::ADDR_ERR_STATUS, v);
      apb(1'b1, tfr_pkg::ADDR_SRC_ERR, 32'h0);
      rchk(tfr_pkg::ADDR_SRC_ERR, v);
      apb(1'b1, tfr_pkg::ADDR_INT_IDENT, 32'h8000);
      repeat (6) @(posedge clk_sys);
      chk(master_error, 32'h0);
      apb(1'b0, tfr_pkg::ADDR_INT_IDENT, 32'h0);
      chk(rdv[15], 32'h0);
    end
    summarize();
  end
endmodule // tfr_recorder_test
`default_nettype wire
